// *** rtl/otg_ctrl_map.svh ***
// Register offsets, field positions, reset values and timing counts for the OTG power and role block.
// Assumes a 100 MHz system clock and the plain address/strobe register port.
`ifndef OTG_CTRL_MAP_SVH
`define OTG_CTRL_MAP_SVH

`define OFS_HW_CONFIG 4'h0
`define OFS_GLOBAL_CONTROL 4'h1
`define OFS_STATUS 4'h2
`define OFS_FLAGS 4'h3
`define OFS_OTG_CONTROL 4'h4
`define OFS_TIMER_CONFIG 4'h5
`define OFS_OTG_FLAGS 4'h6

`define HWC_MANUAL_ROLE 7
`define HWC_ID_ROLE_EN 6
`define HWC_SW_CTRL_EN 4
`define HWC_PAD_REG_EN 0
`define HWC_WMASK 8'hD1
`define HWC_RESET 8'h00

`define GC_ENABLE 7
`define GC_HOST 6
`define GC_FREEZE 5
`define GC_PAD_EN 4
`define GC_ID_IE 1
`define GC_VBUS_IE 0
`define GC_WMASK 8'hF3
`define GC_RESET 8'h20

`define OC_SW_OVERRIDE 2
`define OC_VBUS_REQ 1
`define OC_VBUS_REQ_CLR 0

`define OF_BCERR 2
`define OF_VBERR 1
`define OF_DCONN 0

`define TC_RESET 8'h80

`define CLK_MHZ 100
`define CONNECT_TIMEOUT_MS 300
`define MS_CYCLES(ms) ((ms) * 1000 * `CLK_MHZ)
`define US_CYCLES(us) ((us) * `CLK_MHZ)

`endif

// *** rtl/otg_ctrl_pkg.sv ***
// Types shared by the OTG power and role block.
// Assumes the constants header is included by its users.
package otg_ctrl_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic vbus_valid;
        logic session_valid;
        logic role_id_pin;
        logic dp_pullup;
        logic dm_pullup;
    } cable_s;

    typedef enum {
        PWR_IDLE,
        PWR_WAIT,
        PWR_ON,
        PWR_FAULT
    } pwr_e;

    typedef logic [31:0] count_t;

endpackage : otg_ctrl_pkg

// *** rtl/otg_power_role_ctrl.sv ***
// OTG global control: timer tuning, VBUS hysteresis, power switch with connect time-out, ID role detection.
// Assumes synchronous cable inputs and a register master that never needs a wait state.
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "otg_ctrl_map.svh"

// Notes on behaviour
// [R1] Timer tuning register: two-bit page picks timer, two-bit value sets duration.
// [R2] Page 0: VBUS rise time-out 20/50/70/100 ms, then VBUS error flag.
// [R3] Page 1: session request VBUS pulse 15/23/31/40 ms.
// [R4] Page 2: wait before first session pulse 93/105/118/131 ms.
// [R5] Page 3: minimum accepted session pulse 1us/100us/1ms/11ms.
// [R6] VBUS status sets on high comparator, clears only on session comparator loss or when the pad enable is clear.
// [R7] VBUS transition flag sets on every VBUS status change.
// [R8] Peripheral pull-up stays off while VBUS status is clear.
// [R9] Switch output high when switch enable and VBUS request are both set; the code also needs the software override bit clear.
// [R10] Host: pull-up within 300 ms of VBUS delivery raises connect flag.
// [R11] No connection within 300 ms: connect error flag, switch output dropped.
// [R12] Firmware workaround uses manual pin control and session request flag.
// [R13] No plug means peripheral; ID interrupt only for A-plug insert or removal.
// [R14] ID detection works whatever the global enable says.
// [R15] ID-pin select overrides manual role bit; change only while disabled.
// [R16] Switch-control enable gates switch pin control.
// [R17] Hardware config bit 0 enables the pad regulator.
// [R18] Clearing global enable resets controller, transceiver and clocks.
// [R19] Control bit 6 selects host when set, device when clear.
// [R20] Clock freeze gates controller clocks; resume detection stays alive.
// [R21] VBUS pad enable works even with global enable clear.
// [R22] Control bits 1 and 0 enable ID and VBUS transition interrupts.
// [R23] ID transition flag sets on any ID level change, sticky until cleared.
// [R24] Interrupt request is flag AND enable.
module otg_power_role_ctrl
(
    input wire logic clk,
    input wire logic reset_n,
    input wire otg_ctrl_pkg::reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    input wire otg_ctrl_pkg::cable_s cable,
    input wire logic srp_pulse_active,
    input wire logic periph_attach_req,
    output logic vbus_switch_out,
    output logic periph_pullup_en,
    output logic pad_regulator_en,
    output logic vbus_pad_enable,
    output logic controller_reset_n,
    output logic controller_clk_en,
    output logic host_role,
    output logic id_role_host,
    output logic srp_pulse_done,
    output logic session_request_flag,
    output logic line_discharge_done,
    output logic [1:0] transition_irq
);

    // =====================================================================
    // Timer decode
    // =====================================================================
    function automatic otg_ctrl_pkg::count_t timer_cycles(input logic [1:0] page, input logic [1:0] val);
        otg_ctrl_pkg::count_t r;
        r = 32'h0000_0001;
        unique case (page)
            2'h0: r = val == 2'h0 ? 32'(`MS_CYCLES(20)) : val == 2'h1 ? 32'(`MS_CYCLES(50)) :
                      val == 2'h2 ? 32'(`MS_CYCLES(70)) : 32'(`MS_CYCLES(100)); // R2
            2'h1: r = val == 2'h0 ? 32'(`MS_CYCLES(15)) : val == 2'h1 ? 32'(`MS_CYCLES(23)) :
                      val == 2'h2 ? 32'(`MS_CYCLES(31)) : 32'(`MS_CYCLES(40)); // R3
            2'h2: r = val == 2'h0 ? 32'(`MS_CYCLES(93)) : val == 2'h1 ? 32'(`MS_CYCLES(105)) :
                      val == 2'h2 ? 32'(`MS_CYCLES(118)) : 32'(`MS_CYCLES(131)); // R4
            2'h3: r = val == 2'h0 ? 32'(`US_CYCLES(1)) : val == 2'h1 ? 32'(`US_CYCLES(100)) :
                      val == 2'h2 ? 32'(`MS_CYCLES(1)) : 32'(`MS_CYCLES(11)); // R5
        endcase
        return r;
    endfunction : timer_cycles

    // =====================================================================
    // Registers
    // =====================================================================
    logic [7:0] hw_config_r;
    logic [7:0] usb_global_control_r;
    logic [2:0] otg_control_r;
    logic [1:0] timer_value_r [4];
    logic [1:0] timer_page_r;
    logic vbus_status_r;
    logic id_pin_r;
    logic vbus_transition_flag_r;
    logic id_transition_flag_r;
    logic vbus_error_flag_r;
    logic b_connect_error_flag_r;
    logic dev_connect_flag_r;
    otg_ctrl_pkg::pwr_e pwr_r;
    otg_ctrl_pkg::count_t rise_cnt_r;
    otg_ctrl_pkg::count_t conn_cnt_r;
    otg_ctrl_pkg::count_t srp_cnt_r;
    otg_ctrl_pkg::count_t pulse_cnt_r;
    otg_ctrl_pkg::count_t disc_cnt_r;

    logic wr_hit_flags;
    logic wr_hit_otg_flags;
    logic vbus_status_nxt;
    logic id_change;
    logic host_sel;
    logic vbus_req;
    logic connected;
    logic [3:0] req_addr;

    assign req_addr = reg_req.addr;
    assign wr_hit_flags = reg_req.wr && req_addr == `OFS_FLAGS;
    assign wr_hit_otg_flags = reg_req.wr && req_addr == `OFS_OTG_FLAGS;
    assign vbus_req = otg_control_r[`OC_VBUS_REQ];
    assign connected = cable.dp_pullup || cable.dm_pullup;

    // The pad must be enabled for sensing to see anything, independent of the global enable.
    always_comb
    begin
        vbus_status_nxt = vbus_status_r;
        if (!usb_global_control_r[`GC_PAD_EN]) // R21
            vbus_status_nxt = 1'b0;
        else if (cable.vbus_valid) // R6
            vbus_status_nxt = 1'b1;
        else if (!cable.session_valid) // R6
            vbus_status_nxt = 1'b0;
    end

    assign id_change = cable.role_id_pin != id_pin_r;
    assign host_sel = hw_config_r[`HWC_ID_ROLE_EN] ? !id_pin_r : !hw_config_r[`HWC_MANUAL_ROLE]; // R15

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hw_config_r <= `HWC_RESET;
            usb_global_control_r <= `GC_RESET;
            timer_page_r <= 2'h0;
            timer_value_r <= '{default: 2'h0};
        end
        else if (reg_req.wr)
        begin
            unique case (req_addr)
                `OFS_HW_CONFIG: hw_config_r <= reg_req.wdata & `HWC_WMASK;
                `OFS_GLOBAL_CONTROL: usb_global_control_r <= reg_req.wdata & `GC_WMASK;
                `OFS_TIMER_CONFIG:
                begin
                    timer_page_r <= reg_req.wdata[6:5]; // R1
                    timer_value_r[reg_req.wdata[6:5]] <= reg_req.wdata[1:0]; // R1
                end
                default: ;
            endcase
        end
    end

    // Request-clear beats the request; hardware also drops the request on a connect fault.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            otg_control_r <= 3'h0;
        else if (reg_req.wr && req_addr == `OFS_OTG_CONTROL)
        begin
            otg_control_r[`OC_SW_OVERRIDE] <= reg_req.wdata[`OC_SW_OVERRIDE];
            otg_control_r[`OC_VBUS_REQ] <= reg_req.wdata[`OC_VBUS_REQ] && !reg_req.wdata[`OC_VBUS_REQ_CLR];
            otg_control_r[`OC_VBUS_REQ_CLR] <= 1'b0;
        end
        else if (!usb_global_control_r[`GC_ENABLE] || pwr_r == otg_ctrl_pkg::PWR_FAULT) // R18 R11
            otg_control_r[`OC_VBUS_REQ] <= 1'b0;
    end

    // =====================================================================
    // Cable sensing and transition flags
    // =====================================================================
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vbus_status_r <= 1'b0;
            id_pin_r <= 1'b1;
            vbus_transition_flag_r <= 1'b0;
            id_transition_flag_r <= 1'b0;
        end
        else
        begin
            vbus_status_r <= vbus_status_nxt;
            id_pin_r <= cable.role_id_pin; // R14
            // Set wins over a same-cycle software clear.
            if (vbus_status_nxt != vbus_status_r) // R7
                vbus_transition_flag_r <= 1'b1;
            else if (wr_hit_flags && reg_req.wdata[0])
                vbus_transition_flag_r <= 1'b0;
            if (id_change) // R23 R13
                id_transition_flag_r <= 1'b1;
            else if (wr_hit_flags && reg_req.wdata[1])
                id_transition_flag_r <= 1'b0;
        end
    end

    // =====================================================================
    // VBUS power switch sequencing
    // =====================================================================
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pwr_r <= otg_ctrl_pkg::PWR_IDLE;
            rise_cnt_r <= 32'h0;
            conn_cnt_r <= 32'h0;
        end
        else
        begin
            unique case (pwr_r)
                otg_ctrl_pkg::PWR_IDLE:
                begin
                    rise_cnt_r <= 32'h0;
                    conn_cnt_r <= 32'h0;
                    if (vbus_req && host_sel && !otg_control_r[`OC_SW_OVERRIDE])
                        pwr_r <= otg_ctrl_pkg::PWR_WAIT;
                end
                otg_ctrl_pkg::PWR_WAIT:
                begin
                    rise_cnt_r <= rise_cnt_r + 32'h1;
                    conn_cnt_r <= conn_cnt_r + 32'h1;
                    if (!vbus_req)
                        pwr_r <= otg_ctrl_pkg::PWR_IDLE;
                    else if (connected) // R10
                        pwr_r <= otg_ctrl_pkg::PWR_ON;
                    else if (conn_cnt_r >= 32'(`MS_CYCLES(`CONNECT_TIMEOUT_MS)) - 32'h1) // R11
                        pwr_r <= otg_ctrl_pkg::PWR_FAULT;
                end
                otg_ctrl_pkg::PWR_ON:
                    if (!vbus_req)
                        pwr_r <= otg_ctrl_pkg::PWR_IDLE;
                otg_ctrl_pkg::PWR_FAULT:
                    pwr_r <= otg_ctrl_pkg::PWR_IDLE;
            endcase
        end
    end

    // Host-side error and connect flags; set wins over clear.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vbus_error_flag_r <= 1'b0;
            b_connect_error_flag_r <= 1'b0;
            dev_connect_flag_r <= 1'b0;
        end
        else
        begin
            if (pwr_r == otg_ctrl_pkg::PWR_WAIT && !vbus_status_r
                && rise_cnt_r == timer_cycles(2'h0, timer_value_r[0]) - 32'h1) // R2
                vbus_error_flag_r <= 1'b1;
            else if (wr_hit_otg_flags && reg_req.wdata[`OF_VBERR])
                vbus_error_flag_r <= 1'b0;
            if (pwr_r == otg_ctrl_pkg::PWR_FAULT) // R11
                b_connect_error_flag_r <= 1'b1;
            else if (wr_hit_otg_flags && reg_req.wdata[`OF_BCERR])
                b_connect_error_flag_r <= 1'b0;
            if (pwr_r == otg_ctrl_pkg::PWR_WAIT && connected) // R10
                dev_connect_flag_r <= 1'b1;
            else if (wr_hit_otg_flags && reg_req.wdata[`OF_DCONN])
                dev_connect_flag_r <= 1'b0;
        end
    end

    // =====================================================================
    // Session request timers
    // =====================================================================
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            srp_cnt_r <= 32'h0;
            pulse_cnt_r <= 32'h0;
            disc_cnt_r <= 32'h0;
            session_request_flag <= 1'b0;
            srp_pulse_done <= 1'b0;
            line_discharge_done <= 1'b0;
        end
        else
        begin
            srp_cnt_r <= host_sel && connected ? srp_cnt_r + 32'h1 : 32'h0;
            if (host_sel && srp_cnt_r == timer_cycles(2'h3, timer_value_r[3]) - 32'h1) // R5 R12
                session_request_flag <= 1'b1;
            else if (wr_hit_otg_flags && reg_req.wdata[3])
                session_request_flag <= 1'b0;
            pulse_cnt_r <= srp_pulse_active ? pulse_cnt_r + 32'h1 : 32'h0;
            srp_pulse_done <= srp_pulse_active && pulse_cnt_r == timer_cycles(2'h1, timer_value_r[1]) - 32'h1; // R3
            disc_cnt_r <= !cable.session_valid && !host_sel ? disc_cnt_r + 32'h1 : 32'h0;
            line_discharge_done <= disc_cnt_r >= timer_cycles(2'h2, timer_value_r[2]) - 32'h1 && !host_sel; // R4
        end
    end

    // =====================================================================
    // Outputs and read port
    // =====================================================================
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            vbus_switch_out <= 1'b0;
            periph_pullup_en <= 1'b0;
            pad_regulator_en <= 1'b0;
            vbus_pad_enable <= 1'b0;
            controller_reset_n <= 1'b0;
            controller_clk_en <= 1'b0;
            host_role <= 1'b0;
            id_role_host <= 1'b0;
            transition_irq <= 2'h0;
            reg_rdata <= 8'h00;
        end
        else
        begin
            vbus_switch_out <= hw_config_r[`HWC_SW_CTRL_EN] && vbus_req && !otg_control_r[`OC_SW_OVERRIDE]
                && pwr_r != otg_ctrl_pkg::PWR_FAULT; // R9 R16 R11
            periph_pullup_en <= periph_attach_req && vbus_status_r && !usb_global_control_r[`GC_HOST]
                && usb_global_control_r[`GC_ENABLE]; // R8
            pad_regulator_en <= hw_config_r[`HWC_PAD_REG_EN]; // R17
            vbus_pad_enable <= usb_global_control_r[`GC_PAD_EN]; // R21
            controller_reset_n <= usb_global_control_r[`GC_ENABLE]; // R18
            controller_clk_en <= usb_global_control_r[`GC_ENABLE] && !usb_global_control_r[`GC_FREEZE]; // R18 R20
            host_role <= usb_global_control_r[`GC_HOST]; // R19
            id_role_host <= host_sel; // R15 R13
            transition_irq <= {id_transition_flag_r && usb_global_control_r[`GC_ID_IE],
                vbus_transition_flag_r && usb_global_control_r[`GC_VBUS_IE]}; // R22 R24
            reg_rdata <= 8'h00;
            if (reg_req.rd)
            begin
                unique case (req_addr)
                    `OFS_HW_CONFIG: reg_rdata <= hw_config_r;
                    `OFS_GLOBAL_CONTROL: reg_rdata <= usb_global_control_r;
                    `OFS_STATUS: reg_rdata <= {6'h00, id_pin_r, vbus_status_r};
                    `OFS_FLAGS: reg_rdata <= {6'h00, id_transition_flag_r, vbus_transition_flag_r};
                    `OFS_OTG_CONTROL: reg_rdata <= {5'h00, otg_control_r};
                    `OFS_TIMER_CONFIG: reg_rdata <= `TC_RESET | {1'b0, timer_page_r, 3'h0, timer_value_r[timer_page_r]};
                    `OFS_OTG_FLAGS: reg_rdata <= {4'h0, session_request_flag, b_connect_error_flag_r,
                        vbus_error_flag_r, dev_connect_flag_r};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : otg_power_role_ctrl

// *** sim/cable_partner.sv ***
// Cable model: VBUS comparators, ID plug and a peripheral that pulls up once powered.
// Assumes the bench sets the external VBUS level in millivolts.
`timescale 1ns/10ps

module cable_partner
#(
    parameter int ATTACH_CYCLES = 50
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] ext_vbus_mv,
    input wire logic a_plug,
    input wire logic periph_present,
    input wire logic vbus_switch_out,
    output otg_ctrl_pkg::cable_s cable
);
    logic [15:0] vbus_mv;
    int on_cnt;

    // The local supply wins over any external level while the switch is on.
    assign vbus_mv = vbus_switch_out ? 16'h1388 : ext_vbus_mv;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            on_cnt <= 0;
        else
            on_cnt <= (vbus_switch_out && periph_present) ? on_cnt + 1 : 0;
    end

    always_comb
    begin
        cable.vbus_valid = vbus_mv >= 16'h1130;
        cable.session_valid = vbus_mv >= 16'h0578;
        cable.role_id_pin = !a_plug;
        cable.dp_pullup = on_cnt >= ATTACH_CYCLES;
        cable.dm_pullup = 1'b0;
    end
endmodule : cable_partner

// *** sim/otg_power_role_ctrl_props.sv ***
// Port-level assertions for the OTG power and role block.
// Assumes it is bound into otg_power_role_ctrl and sees only that module's ports.
`timescale 1ns/10ps
`include "otg_ctrl_map.svh"

module otg_power_role_props
(
    input wire logic clk,
    input wire logic reset_n,
    input wire otg_ctrl_pkg::reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    input wire otg_ctrl_pkg::cable_s cable,
    input wire logic vbus_switch_out,
    input wire logic periph_pullup_en,
    input wire logic pad_regulator_en,
    input wire logic vbus_pad_enable,
    input wire logic controller_reset_n,
    input wire logic controller_clk_en,
    input wire logic host_role
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ==========================================================================
    // Register port
    rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the read slot");
    timer_read_a: assert property (
        reg_req.rd && reg_req.addr == `OFS_TIMER_CONFIG |=> reg_rdata[7] && reg_rdata[4:2] == 3'h0)
        else $error("timer config read shows wrong fixed bits");
    id_status_a: assert property (
        reg_req.rd && reg_req.addr == `OFS_STATUS && $stable(cable.role_id_pin)
        |=> reg_rdata[1] == $past(cable.role_id_pin))
        else $error("status id bit differs from the id pin");

    // ==========================================================================
    // Outputs that follow control bits or cable levels
    pad_reg_a: assert property (
        reg_req.wr && reg_req.addr == `OFS_HW_CONFIG ##1 !(reg_req.wr && reg_req.addr == `OFS_HW_CONFIG)
        |=> pad_regulator_en == $past(reg_req.wdata[0], 2))
        else $error("pad regulator enable does not follow its bit");
    gc_out_a: assert property (
        reg_req.wr && reg_req.addr == `OFS_GLOBAL_CONTROL ##1 !(reg_req.wr && reg_req.addr == `OFS_GLOBAL_CONTROL)
        |=> host_role == $past(reg_req.wdata[6], 2) && vbus_pad_enable == $past(reg_req.wdata[4], 2))
        else $error("host or pad enable output does not follow its bit");
    clk_gate_a: assert property (
        reg_req.wr && reg_req.addr == `OFS_GLOBAL_CONTROL ##1 !(reg_req.wr && reg_req.addr == `OFS_GLOBAL_CONTROL)
        |=> controller_clk_en == ($past(reg_req.wdata[7], 2) && !$past(reg_req.wdata[5], 2)))
        else $error("controller clock enable wrong");
    clk_reset_a: assert property (controller_clk_en |-> controller_reset_n)
        else $error("controller clocked while held in reset");
    pullup_drop_a: assert property (
        $fell(cable.session_valid) && !cable.vbus_valid |-> ##3 !periph_pullup_en)
        else $error("pull-up still on after vbus loss");
    override_off_a: assert property (
        reg_req.wr && reg_req.addr == `OFS_OTG_CONTROL && reg_req.wdata[2] |-> ##3 !vbus_switch_out)
        else $error("switch output on under software override");
endmodule : otg_power_role_props

bind otg_power_role_ctrl otg_power_role_props props_i (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .cable(cable), .vbus_switch_out(vbus_switch_out), .periph_pullup_en(periph_pullup_en),
    .pad_regulator_en(pad_regulator_en), .vbus_pad_enable(vbus_pad_enable),
    .controller_reset_n(controller_reset_n), .controller_clk_en(controller_clk_en), .host_role(host_role));

// *** sim/tb.sv ***
// Self-checking bench for the OTG power and role block.
// Assumes the design, its header and the cable model are compiled alongside.
`timescale 1ns/10ps
`include "otg_ctrl_map.svh"

module tb;
    logic clk, reset_n, a_plug, periph_present, periph_attach_req;
    logic [15:0] ext_mv;
    otg_ctrl_pkg::reg_req_s reg_req;
    otg_ctrl_pkg::cable_s cable;
    logic [7:0] reg_rdata;
    logic [1:0] transition_irq;
    logic vbus_switch_out, periph_pullup_en, pad_regulator_en, vbus_pad_enable;
    logic controller_reset_n, controller_clk_en, host_role, id_role_host;
    int miscompares = 0;
    int checks_done = 0;

    otg_power_role_ctrl dut (.clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .cable(cable), .srp_pulse_active(1'b0), .periph_attach_req(periph_attach_req),
        .vbus_switch_out(vbus_switch_out), .periph_pullup_en(periph_pullup_en),
        .pad_regulator_en(pad_regulator_en), .vbus_pad_enable(vbus_pad_enable),
        .controller_reset_n(controller_reset_n), .controller_clk_en(controller_clk_en),
        .host_role(host_role), .id_role_host(id_role_host), .srp_pulse_done(), .session_request_flag(),
        .line_discharge_done(), .transition_irq(transition_irq));
    cable_partner #(.ATTACH_CYCLES(50)) partner (.clk(clk), .reset_n(reset_n), .ext_vbus_mv(ext_mv),
        .a_plug(a_plug), .periph_present(periph_present), .vbus_switch_out(vbus_switch_out), .cable(cable));

    // ==========================================================================
    // Bus and checking helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req.addr <= a;
        reg_req.wdata <= d;
        reg_req.wr <= 1'b1;
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask : wr
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge clk);
        reg_req.addr <= a;
        reg_req.rd <= 1'b1;
        @(posedge clk);
        reg_req.rd <= 1'b0;
        #1 check(reg_rdata & m, e);
    endtask : rdchk
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle
    task automatic vbus(input logic [15:0] mv);
        @(posedge clk);
        ext_mv <= mv;
        idle(5);
    endtask : vbus

    // ==========================================================================
    // Scenarios
    task automatic t_reset;
        rdchk(`OFS_HW_CONFIG, 8'h00);
        rdchk(`OFS_GLOBAL_CONTROL, 8'h20);
        rdchk(`OFS_STATUS, 8'h02);
        rdchk(4'hF, 8'h00);
        check(controller_reset_n, 1'b0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_timer;
        for (int p = 0; p < 4; p++)
            for (int v = 3; v >= 0; v--)
            begin
                wr(`OFS_TIMER_CONFIG, {1'b0, p[1:0], 3'h7, v[1:0]});
                rdchk(`OFS_TIMER_CONFIG, {1'b1, p[1:0], 3'h0, v[1:0]});
            end
        $display("timer test done");
    endtask : t_timer
    task automatic t_config;
        wr(`OFS_HW_CONFIG, 8'hAF);
        rdchk(`OFS_HW_CONFIG, 8'h81);
        wr(`OFS_GLOBAL_CONTROL, 8'hFF);
        rdchk(`OFS_GLOBAL_CONTROL, 8'hF3);
        check({controller_clk_en, host_role, pad_regulator_en}, 3'h3);
        wr(`OFS_GLOBAL_CONTROL, 8'h80);
        wr(`OFS_HW_CONFIG, 8'h00);
        idle(2);
        check({controller_clk_en, controller_reset_n, host_role, pad_regulator_en}, 4'hC);
        wr(`OFS_GLOBAL_CONTROL, 8'h00);
        idle(2);
        check({controller_clk_en, controller_reset_n}, 2'h0);
        $display("config test done");
    endtask : t_config
    task automatic t_vbus;
        wr(`OFS_GLOBAL_CONTROL, 8'h11);
        vbus(16'h07D0);
        rdchk(`OFS_STATUS, 8'h02);
        vbus(16'h1388);
        rdchk(`OFS_STATUS, 8'h03);
        rdchk(`OFS_FLAGS, 8'h01);
        check(transition_irq, 2'b01);
        wr(`OFS_FLAGS, 8'h01);
        idle(3);
        check(transition_irq, 2'b00);
        vbus(16'h0BB8);
        rdchk(`OFS_STATUS, 8'h03);
        rdchk(`OFS_FLAGS, 8'h00);
        vbus(16'h03E8);
        rdchk(`OFS_STATUS, 8'h02);
        rdchk(`OFS_FLAGS, 8'h01);
        wr(`OFS_GLOBAL_CONTROL, 8'h10);
        idle(3);
        check(transition_irq, 2'b00);
        wr(`OFS_FLAGS, 8'h01);
        $display("vbus test done");
    endtask : t_vbus
    task automatic t_id;
        wr(`OFS_GLOBAL_CONTROL, 8'h02);
        @(posedge clk);
        a_plug <= 1'b1;
        idle(4);
        rdchk(`OFS_STATUS, 8'h00);
        rdchk(`OFS_FLAGS, 8'h02);
        check(transition_irq, 2'b10);
        wr(`OFS_HW_CONFIG, 8'hC0);
        idle(3);
        check(id_role_host, 1'b1);
        wr(`OFS_HW_CONFIG, 8'h80);
        idle(3);
        check(id_role_host, 1'b0);
        wr(`OFS_FLAGS, 8'h02);
        @(posedge clk);
        a_plug <= 1'b0;
        idle(4);
        rdchk(`OFS_FLAGS, 8'h02);
        wr(`OFS_FLAGS, 8'h02);
        $display("id test done");
    endtask : t_id
    task automatic t_switch;
        wr(`OFS_GLOBAL_CONTROL, 8'hD0);
        wr(`OFS_HW_CONFIG, 8'h10);
        wr(`OFS_OTG_CONTROL, 8'h02);
        idle(3);
        check(vbus_switch_out, 1'b1);
        idle(200);
        rdchk(`OFS_OTG_FLAGS, 8'h09, 8'h0F);
        wr(`OFS_OTG_CONTROL, 8'h01);
        idle(3);
        check(vbus_switch_out, 1'b0);
        wr(`OFS_HW_CONFIG, 8'h00);
        wr(`OFS_OTG_CONTROL, 8'h02);
        idle(3);
        check(vbus_switch_out, 1'b0);
        wr(`OFS_HW_CONFIG, 8'h10);
        wr(`OFS_OTG_CONTROL, 8'h06);
        idle(3);
        check(vbus_switch_out, 1'b0);
        wr(`OFS_OTG_CONTROL, 8'h01);
        $display("switch test done");
    endtask : t_switch
    task automatic t_pullup;
        wr(`OFS_HW_CONFIG, 8'h80);
        wr(`OFS_GLOBAL_CONTROL, 8'h90);
        periph_attach_req <= 1'b1;
        vbus(16'h0000);
        check(periph_pullup_en, 1'b0);
        vbus(16'h1388);
        check(periph_pullup_en, 1'b1);
        vbus(16'h03E8);
        check(periph_pullup_en, 1'b0);
        $display("pull-up test done");
    endtask : t_pullup

    // ==========================================================================
    // Run control
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        reset_n = 1'b0;
        reg_req = '0;
        ext_mv = 16'h0000;
        a_plug = 1'b0;
        periph_present = 1'b1;
        periph_attach_req = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_reset();
        t_timer();
        t_config();
        t_vbus();
        t_id();
        t_switch();
        t_pullup();
        print_verdict();
    end

    // The scenarios need about 450 cycles; this cuts a hang well beyond that.
    initial
    begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule : tb
